/* File: pkg/gpio_pkg.sv */
// ----------------------------------------------------------------------------
// register map, reset values, bus carriers
// ----------------------------------------------------------------------------
package gpio_pkg;

  localparam int          ADR_W        = 8;
  localparam int          DAT_W        = 32;
  localparam int          SEL_W        = 4;

  localparam logic [7:0]  OFS_OUT      = 8'h00;
  localparam logic [7:0]  OFS_DIR      = 8'h04;
  localparam logic [7:0]  OFS_PINS     = 8'h08;
  localparam logic [7:0]  OFS_CTRL     = 8'h0C;
  localparam logic [7:0]  OFS_OUT_SET  = 8'h10;
  localparam logic [7:0]  OFS_OUT_CLR  = 8'h14;
  localparam logic [7:0]  OFS_DIR_SET  = 8'h18;
  localparam logic [7:0]  OFS_DIR_CLR  = 8'h1C;

  localparam int          CTRL_PU_OFF_BIT = 0;

  localparam logic [31:0] RST_OUT      = 32'h0000_0000;
  localparam logic [31:0] RST_DIR      = 32'h0000_0000;
  localparam logic        RST_PU_OFF   = 1'b0;

  typedef struct packed {
    logic               cyc;
    logic               stb;
    logic               we;
    logic [ADR_W-1:0]   adr;
    logic [SEL_W-1:0]   sel;
    logic [DAT_W-1:0]   dat;
  } wb_req_t;

  typedef struct packed {
    logic               ack;
    logic               err;
    logic [DAT_W-1:0]   dat;
  } wb_rsp_t;

endpackage : gpio_pkg

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// pin sampler: falling-edge hold stage then rising-edge register
// ----------------------------------------------------------------------------
module pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // pins and sample
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] sample_o
);

  logic [WIDTH-1:0] hold_q;
  logic [WIDTH-1:0] hold_d;
  logic [WIDTH-1:0] samp_q;
  logic [WIDTH-1:0] samp_d;

  // ----------------------------------------------------------------------------
  // two stages
  // ----------------------------------------------------------------------------
  always_comb begin
    hold_d = pin_i;
    samp_d = hold_q;
  end

  // value seen while clock is high is held at the falling edge
  always_ff @(negedge clk_i) begin
    if (rst_i) begin
      hold_q <= '0;
    end else begin
      hold_q <= hold_d;
    end
  end

  // held value moves into the sample at the next rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      samp_q <= '0;
    end else begin
      samp_q <= samp_d;
    end
  end

  assign sample_o = samp_q;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  a_sync_settle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ($past(pin_i, 2) == pin_i && $past(pin_i) == pin_i && $past(rst_i, 2) == 1'b0) |-> sample_o == pin_i)
    else $error("pin sample did not settle within one and a half periods");

endmodule : pin_sync

/* File: rtl/gpio_port.sv */
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - single-bit set or clear of direction or data leaves other pins unchanged
// - data, direction and input pins each have their own address
// - input pins location is read-only; data and direction are read/write
// - global pull-up disable turns off every pull-up
// - direction one makes an output, zero an input
// - input with data one and no global disable gets its pull-up
// - reset tri-states all pins at once, even with no clock
// - output drives the data bit level; output pins never pulled up
// - pin level readable whatever the direction
// - sampling through a falling-edge hold stage then a rising-edge register
// - external change seen between half and one and a half periods later
// - written value readable one period later; software waits one instruction
// - alternate function on some pins leaves others as plain I/O
module gpio_port
  import gpio_pkg::*;
#(
  parameter int N_PINS = 8
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire gpio_pkg::wb_req_t wb_req_i,
  output gpio_pkg::wb_rsp_t      wb_rsp_o,
  // pads
  input  wire logic [N_PINS-1:0] pad_i,
  output logic      [N_PINS-1:0] pad_o,
  output logic      [N_PINS-1:0] pad_oe_o,
  output logic      [N_PINS-1:0] pad_pu_o,
  // alternate function override
  input  wire logic [N_PINS-1:0] alt_en_i,
  input  wire logic [N_PINS-1:0] alt_oe_i,
  input  wire logic [N_PINS-1:0] alt_o_i
);

  import gpio_pkg::*;

  if (N_PINS < 1 || N_PINS > DAT_W) begin : g_bad_width
    $error("N_PINS must lie between 1 and 32");
  end

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  bus_state_t         state_q;
  bus_state_t         state_d;
  logic               err_q;
  logic               err_d;
  logic [DAT_W-1:0]   rdat_q;
  logic [DAT_W-1:0]   rdat_d;
  logic [N_PINS-1:0]  out_q;
  logic [N_PINS-1:0]  out_d;
  logic [N_PINS-1:0]  dir_q;
  logic [N_PINS-1:0]  dir_d;
  logic               pu_off_q;
  logic               pu_off_d;
  logic [N_PINS-1:0]  pins_q;
  logic               req;
  logic               wr_en;
  logic               adr_ok;
  logic [N_PINS-1:0]  lane_m;
  logic [N_PINS-1:0]  wdat_m;

  // ----------------------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------------------
  pin_sync #(
    .WIDTH    (N_PINS)
  ) u_sync (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .pin_i    (pad_i),
    .sample_o (pins_q)
  );

  // ----------------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------------
  assign req = wb_req_i.cyc & wb_req_i.stb;

  always_comb begin
    case (wb_req_i.adr)
      OFS_OUT, OFS_DIR, OFS_PINS, OFS_CTRL,
      OFS_OUT_SET, OFS_OUT_CLR, OFS_DIR_SET, OFS_DIR_CLR: begin
        adr_ok = 1'b1;
      end
      default: begin
        adr_ok = 1'b0;
      end
    endcase
  end

  // byte enables reach only the pins in their lane
  always_comb begin
    lane_m = '0;
    for (int b = 0; b < N_PINS; b++) begin
      lane_m[b] = wb_req_i.sel[b / 8];
    end
    wdat_m = wb_req_i.dat[N_PINS-1:0] & lane_m;
  end

  // write lands on the edge where the master sees ack
  assign wr_en = (state_q == BUS_ACK) & req & wb_req_i.we & ~err_q;

  // ----------------------------------------------------------------------------
  // bus handshake and read data
  // ----------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    err_d   = err_q;
    rdat_d  = rdat_q;
    case (state_q)
      BUS_IDLE: begin
        if (req) begin
          state_d = BUS_ACK;
          err_d   = ~adr_ok;
          rdat_d  = '0;
          case (wb_req_i.adr)
            OFS_OUT: begin
              rdat_d[N_PINS-1:0] = out_q;
            end
            OFS_DIR: begin
              rdat_d[N_PINS-1:0] = dir_q;
            end
            OFS_PINS: begin
              rdat_d[N_PINS-1:0] = pins_q;
            end
            OFS_CTRL: begin
              rdat_d[CTRL_PU_OFF_BIT] = pu_off_q;
            end
            default: begin
              rdat_d = '0;
            end
          endcase
        end
      end
      BUS_ACK: begin
        state_d = BUS_IDLE;
        err_d   = 1'b0;
      end
      default: begin
        state_d = BUS_IDLE;
        err_d   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= BUS_IDLE;
      err_q   <= 1'b0;
      rdat_q  <= '0;
    end else begin
      state_q <= state_d;
      err_q   <= err_d;
      rdat_q  <= rdat_d;
    end
  end

  always_comb begin
    wb_rsp_o.ack = (state_q == BUS_ACK) & ~err_q;
    wb_rsp_o.err = (state_q == BUS_ACK) & err_q;
    wb_rsp_o.dat = rdat_q;
  end

  // ----------------------------------------------------------------------------
  // port registers
  // ----------------------------------------------------------------------------
  always_comb begin
    out_d = out_q;
    dir_d = dir_q;
    pu_off_d = pu_off_q;
    if (wr_en) begin
      case (wb_req_i.adr)
        OFS_OUT: begin
          out_d = (out_q & ~lane_m) | wdat_m;
        end
        OFS_DIR: begin
          dir_d = (dir_q & ~lane_m) | wdat_m;
        end
        OFS_CTRL: begin
          if (wb_req_i.sel[0]) begin
            pu_off_d = wb_req_i.dat[CTRL_PU_OFF_BIT];
          end
        end
        OFS_OUT_SET: begin
          out_d = out_q | wdat_m;
        end
        OFS_OUT_CLR: begin
          out_d = out_q & ~wdat_m;
        end
        OFS_DIR_SET: begin
          dir_d = dir_q | wdat_m;
        end
        OFS_DIR_CLR: begin
          dir_d = dir_q & ~wdat_m;
        end
        default: begin
          out_d = out_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_q <= RST_OUT[N_PINS-1:0];
      dir_q <= RST_DIR[N_PINS-1:0];
      pu_off_q <= RST_PU_OFF;
    end else begin
      out_q <= out_d;
      dir_q <= dir_d;
      pu_off_q <= pu_off_d;
    end
  end

  // ----------------------------------------------------------------------------
  // pad drivers
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < N_PINS; i++) begin : g_pin
    always_comb begin
      if (rst_i) begin
        pad_oe_o[i] = 1'b0;
        pad_o[i]    = 1'b0;
        pad_pu_o[i] = 1'b0;
      end else if (alt_en_i[i]) begin
        pad_oe_o[i] = alt_oe_i[i];
        pad_o[i]    = alt_o_i[i];
        pad_pu_o[i] = 1'b0;
      end else begin
        pad_oe_o[i] = dir_q[i];
        pad_o[i]    = out_q[i];
        pad_pu_o[i] = ~dir_q[i] & out_q[i] & ~pu_off_q;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  sequence s_req_new;
    req && state_q == BUS_IDLE;
  endsequence

  sequence s_answer;
    (wb_rsp_o.ack || wb_rsp_o.err) ##1 !(wb_rsp_o.ack || wb_rsp_o.err);
  endsequence

  sequence s_set_write;
    wr_en && (wb_req_i.adr == OFS_OUT_SET || wb_req_i.adr == OFS_DIR_SET);
  endsequence

  sequence s_clr_write;
    wr_en && (wb_req_i.adr == OFS_OUT_CLR || wb_req_i.adr == OFS_DIR_CLR);
  endsequence

  a_reset_tristate: assert property (
    @(posedge clk_i) rst_i |-> (pad_oe_o == '0 && pad_pu_o == '0))
    else $error("pins not tri-stated in reset");

  a_reset_values: assert property (
    @(posedge clk_i) $fell(rst_i) |-> (dir_q == '0 && out_q == '0 && pad_pu_o == '0))
    else $error("direction or data not zero after reset");

  a_dir_drives: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ((pad_oe_o ^ dir_q) & ~alt_en_i) == '0)
    else $error("output enable differs from direction");

  a_out_level: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (((pad_o ^ out_q) & dir_q & ~alt_en_i) == '0) && ((pad_pu_o & dir_q) == '0))
    else $error("output level wrong or output pulled up");

  a_global_pu_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pu_off_q |-> pad_pu_o == '0)
    else $error("pull-up active under global disable");

  a_pullup_on: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !pu_off_q |-> ((pad_pu_o ^ (~dir_q & out_q)) & ~alt_en_i) == '0)
    else $error("pull-up state wrong for input pin");

  a_bit_set_only: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_set_write |=> (((out_q ^ $past(out_q)) | (dir_q ^ $past(dir_q))) & ~$past(wdat_m)) == '0)
    else $error("bit set disturbed other pins");

  a_pins_readonly: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_en && wb_req_i.adr == OFS_PINS) |=> ($stable(out_q) && $stable(dir_q) && $stable(pu_off_q)))
    else $error("write to input pins changed state");

  a_pins_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_req_new and (!wb_req_i.we && wb_req_i.adr == OFS_PINS)) |=>
      wb_rsp_o.ack && wb_rsp_o.dat[N_PINS-1:0] == $past(pins_q))
    else $error("input pins read wrong");

  a_dir_location: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_req_new and (!wb_req_i.we && wb_req_i.adr == OFS_DIR)) |=>
      wb_rsp_o.dat[N_PINS-1:0] == $past(dir_q) ##0 s_answer)
    else $error("direction read wrong or answer malformed");

  a_bit_clear_only: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_clr_write |=> (((out_q ^ $past(out_q)) | (dir_q ^ $past(dir_q))) & ~$past(wdat_m)) == '0)
    else $error("bit clear disturbed other pins");

  a_unmapped_err: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_req_new and !adr_ok) |=> (wb_rsp_o.err && !wb_rsp_o.ack))
    else $error("unmapped address not refused");

  a_err_no_effect: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_rsp_o.err |=> ($stable(out_q) && $stable(dir_q) && $stable(pu_off_q)))
    else $error("refused access changed state");

  a_answer_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wb_rsp_o.ack || wb_rsp_o.err) |=> !(wb_rsp_o.ack || wb_rsp_o.err))
    else $error("answer held longer than one cycle");

  a_data_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_en && wb_req_i.adr == OFS_OUT && lane_m == '1) |=>
      out_q == $past(wb_req_i.dat[N_PINS-1:0]))
    else $error("data register write lost");

  a_pu_off_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_en && wb_req_i.adr == OFS_CTRL && wb_req_i.sel[0]) |=>
      pu_off_q == $past(wb_req_i.dat[CTRL_PU_OFF_BIT]))
    else $error("pull-up disable write lost");

  a_reset_drive: assert property (
    @(posedge clk_i) rst_i |-> pad_o == '0)
    else $error("pin drive not low in reset");

endmodule : gpio_port

/* File: testbench/pad_world.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// pin world: device drive, external driver, pull-up, else floating
// ----------------------------------------------------------------------------
module pad_world #(
  parameter int N = 8
) (
  // clock
  input  wire logic         clk_i,
  // device side
  input  wire logic [N-1:0] drive_i,
  input  wire logic [N-1:0] oe_i,
  input  wire logic [N-1:0] pu_i,
  // external driver
  input  wire logic [N-1:0] ext_en_i,
  input  wire logic [N-1:0] ext_val_i,
  // resolved level
  output logic      [N-1:0] level_o
);
  logic [N-1:0] float_q = '0;

  // an undriven line wanders every cycle
  always_ff @(posedge clk_i) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (oe_i[i]) level_o[i] = drive_i[i];
      else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
      else if (pu_i[i]) level_o[i] = 1'b1;
      else level_o[i] = float_q[i];
    end
  end
endmodule : pad_world

/* File: testbench/general_digital_io_port_tb.sv */
`timescale 1ns/1ps
module general_digital_io_port_tb;
  import gpio_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  wb_req_t     wb_req = '0;
  wb_rsp_t     wb_rsp;
  logic [7:0]  pad_o, pad_oe, pad_pu, lvl;
  logic [7:0]  alt_en = '0, alt_oe = '0, alt_o = '0, ext_en = '0, ext_v = '0;
  logic [31:0] q;
  logic        e;
  int          failures = 0, tests_run = 0, seed = 5081, out_m, dir_m, pu_off_m, b;

  always #10 clk_i = ~clk_i;

  gpio_port #(.N_PINS(8)) i_gpio_port (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .pad_i(lvl), .pad_o(pad_o), .pad_oe_o(pad_oe), .pad_pu_o(pad_pu),
    .alt_en_i(alt_en), .alt_oe_i(alt_oe), .alt_o_i(alt_o));
  pad_world #(.N(8)) i_pad_world (.clk_i(clk_i), .drive_i(pad_o), .oe_i(pad_oe), .pu_i(pad_pu),
    .ext_en_i(ext_en), .ext_val_i(ext_v), .level_o(lvl));

  task automatic end_of_test;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask : check

  // classic single cycle, entered right after a rising edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (!(wb_rsp.ack || wb_rsp.err) && n < 50);
    if (n >= 50) begin
      failures++;
      end_of_test();
    end
    q = wb_rsp.dat;
    e = wb_rsp.err;
    wb_req <= '0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input string n, input logic [7:0] a, input int x);
    wb(1'b0, a, 32'h0);
    check(n, q, 32'(x));
  endtask : rd

  // pad outputs and sampled levels against the reference model
  task automatic pads;
    logic [7:0] d, o, oe, dv, pu, m;
    d = dir_m[7:0];
    o = out_m[7:0];
    oe = (alt_en & alt_oe) | (~alt_en & d);
    dv = (alt_en & alt_o) | (~alt_en & o);
    pu = ~d & o & ~{8{pu_off_m[0]}} & ~alt_en;
    check("oe", 32'(pad_oe), 32'(oe));
    check("drive", 32'(pad_o), 32'(dv));
    check("pullup", 32'(pad_pu), 32'(pu));
    m = oe | ext_en | pu;
    wb(1'b0, OFS_PINS, 32'h0);
    check("pins", 32'(q[7:0] & m), 32'(((oe & dv) | (~oe & ext_en & ext_v) | (~oe & ~ext_en & pu)) & m));
  endtask : pads

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    out_m = 0;
    dir_m = 0;
    pu_off_m = 0;
    @(posedge clk_i);
    rd("out", OFS_OUT, 0);
    rd("dir", OFS_DIR, 0);
    rd("ctrl", OFS_CTRL, 0);
    wb(1'b1, OFS_OUT, 32'hA5);
    out_m = 'hA5;
    wb(1'b1, OFS_DIR, 32'h3C);
    dir_m = 'h3C;
    wb(1'b1, OFS_PINS, 32'hFF);
    rd("out rw", OFS_OUT, 'hA5);
    rd("dir rw", OFS_DIR, 'h3C);
    rd("set reads", OFS_OUT_SET, 0);
    wb(1'b0, 8'h20, 32'h0);
    check("err", 32'(e), 32'h1);
    pads();
    // single-bit set or clear moves, or in one case of five a global pull-up disable write to the control register
    repeat (150) begin
      alt_en <= 8'($random(seed) & $random(seed));
      alt_oe <= 8'($random(seed));
      alt_o  <= 8'($random(seed));
      ext_en <= 8'($random(seed));
      ext_v  <= 8'($random(seed));
      b = $unsigned($random(seed)) % 8;
      case ($unsigned($random(seed)) % 5)
        0: begin wb(1'b1, OFS_OUT_SET, 32'(1 << b)); out_m |= 1 << b; end
        1: begin wb(1'b1, OFS_OUT_CLR, 32'(1 << b)); out_m &= ~(1 << b); end
        2: begin wb(1'b1, OFS_DIR_SET, 32'(1 << b)); dir_m |= 1 << b; end
        3: begin wb(1'b1, OFS_DIR_CLR, 32'(1 << b)); dir_m &= ~(1 << b); end
        default: begin pu_off_m = $random(seed) & 1; wb(1'b1, OFS_CTRL, 32'(pu_off_m)); end
      endcase
      pads();
      rd("out", OFS_OUT, out_m);
      rd("dir", OFS_DIR, dir_m);
    end
    alt_en <= '0;
    wb(1'b1, OFS_DIR, 32'h0);
    dir_m = 0;
    ext_en <= '1;
    ext_v  <= '0;
    repeat (3) @(posedge clk_i);
    ext_v <= 8'h5A;
    wb(1'b0, OFS_PINS, 32'h0);
    check("sync early", q, 32'h0);
    wb(1'b0, OFS_PINS, 32'h0);
    check("sync", q, 32'h5A);
    wb(1'b1, OFS_DIR, 32'hFF);
    rst_i <= 1'b1;
    #1;
    check("rst oe", 32'(pad_oe), 32'h0);
    check("rst pu", 32'(pad_pu), 32'h0);
    check("rst drive", 32'(pad_o), 32'h0);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    out_m = 0;
    dir_m = 0;
    pu_off_m = 0;
    @(posedge clk_i);
    rd("out", OFS_OUT, 0);
    rd("dir", OFS_DIR, 0);
    end_of_test();
  end
endmodule : general_digital_io_port_tb
